// file: verilog/ptmc_top.v
// Purpose: Trigger source and operating mode control of a pulse generator
// Assumes: Single 10 MHz clock, settings arrive as one-cycle write strobes
// Notes: Pulse timing is a simple fixed-width stand-in for the real timing path
// Notes: SINGLE_TRIGGER_MODE_O marks only triggers that start a pulse or a burst
// Summary of operation
// - Auto mode, the default, runs continuously and ignores the external input.
// - Trigger mode: one pulse per trigger; refused while duty ratio mode is on.
// - Gate mode: pulses run while the gate is active, stop when it ends.
// - Burst mode: each trigger emits burst_pulse_count pulses.
// - Burst mode refused when the repetition interval is below 5.00 ns.
// - External width mode: output width and period follow the external input.
// - One mode setting shared by both channels.
// - Mode query returns one of five mode codes.
// - Rising edge triggers by default, falling edge when negative is set.
// - Only one edge polarity at a time; both edges request is rejected.
// - Edge query reports positive or negative in use.
// - External enable off by default blocks input triggers; on acts on them.
// - One external enable flag shared by both channels.
// - A software trigger clears the external enable.
// - Enable query reports off or on.
// - Software trigger acts like a group execute trigger in trigger or burst mode.
`timescale 1ns/10ps
`default_nettype none
`include "ptmc_defines.vh"

module ptmc_top (
  // Clock and reset
  input wire SYS_CLK_I,
  input wire ARST_N_I,
  // External trigger pin
  input wire EXT_SINGLE_TRIGGER_MODE_I,
  // Mode setting
  input wire MODE_WR_I,
  input wire [`PTMC_MODE_W-1:0] MODE_I,
  // Edge setting
  input wire EDGE_WR_I,
  input wire [`PTMC_EDGE_W-1:0] EDGE_I,
  // External enable setting
  input wire EXT_EN_WR_I,
  input wire EXT_EN_I,
  // Software trigger command
  input wire SW_SINGLE_TRIGGER_MODE_I,
  // Conflict inputs from other settings
  input wire DUTY_RATIO_MODE_I,
  input wire [`PTMC_PERIOD_W-1:0] REP_INTERVAL_PS_I,
  input wire [`PTMC_COUNT_W-1:0] BURST_COUNT_I,
  // Error flag clear
  input wire ERR_CLR_I,
  // Query answers
  output reg [`PTMC_MODE_W-1:0] MODE_O,
  output reg EDGE_NEG_O,
  output reg EXT_EN_O,
  output reg ERR_O,
  // Shared pulse output to both channels
  output reg PULSE_O,
  output reg SINGLE_TRIGGER_MODE_O
);

  localparam ST_IDLE = 3'h1;
  localparam ST_HIGH = 3'h2;
  localparam ST_LOW = 3'h4;

  // Synchronised pin signals
  wire ext_level;
  wire ext_edge;
  wire ext_prev;
  // Internal state and next values
  reg [`PTMC_MODE_W-1:0] mode_reg;
  reg [`PTMC_MODE_W-1:0] mode_next;
  reg neg_reg;
  reg neg_next;
  reg ext_en_reg;
  reg ext_en_next;
  reg err_reg;
  reg err_next;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`PTMC_TIMER_W-1:0] timer_reg;
  reg [`PTMC_TIMER_W-1:0] timer_next;
  reg [`PTMC_COUNT_W-1:0] left_reg;
  reg [`PTMC_COUNT_W-1:0] left_next;
  reg ext_single_trigger_mode;
  reg single_trigger_mode;
  reg single_trigger_mode_take;
  reg pulse_next;

  // Check that a mode code is one of the five legal ones
  function mode_legal;
    input [`PTMC_MODE_W-1:0] m;
    begin
      mode_legal = (m == `PTMC_MODE_AUTO) || (m == `PTMC_MODE_SINGLE_TRIGGER_MODE) ||
                   (m == `PTMC_MODE_GATE) || (m == `PTMC_MODE_BURST) ||
                   (m == `PTMC_MODE_EXTERNAL_WIDTH_MODE);
    end
  endfunction

  // Gate is open: gate mode, input enabled, synced level at its active polarity
  function gate_active;
    input [`PTMC_MODE_W-1:0] m;
    input en;
    input lvl;
    input neg;
    begin
      gate_active = (m == `PTMC_MODE_GATE) && en && (lvl != neg);
    end
  endfunction

  // Timer step, shared by the pulse and gap phases
  function [`PTMC_TIMER_W-1:0] tick_down;
    input [`PTMC_TIMER_W-1:0] t;
    begin
      tick_down = t - `PTMC_TIMER_ONE;
    end
  endfunction

  // Trigger pin synchroniser
  ptmc_sync u_sync (
    .sys_clk_i(SYS_CLK_I),
    .arst_n_i(ARST_N_I),
    .pin_i(EXT_SINGLE_TRIGGER_MODE_I),
    .level_o(ext_level)
  );

  // Selected edge detector
  ptmc_edge u_edge (
    .sys_clk_i(SYS_CLK_I),
    .arst_n_i(ARST_N_I),
    .level_i(ext_level),
    .neg_i(neg_reg),
    .edge_o(ext_edge),
    .prev_o(ext_prev)
  );

  // Settings update with conflict checks
  always @* begin
    mode_next = mode_reg;
    neg_next = neg_reg;
    ext_en_next = ext_en_reg;
    err_next = err_reg;
    // Clear first so that a new error in this cycle still sets the flag
    if (ERR_CLR_I) begin
      err_next = 1'b0;
    end
    // Mode write: a refused code leaves the mode alone
    if (MODE_WR_I) begin
      if (!mode_legal(MODE_I)) begin
        err_next = 1'b1;
      end else if (MODE_I == `PTMC_MODE_SINGLE_TRIGGER_MODE && DUTY_RATIO_MODE_I) begin
        err_next = 1'b1;
      end else if (MODE_I == `PTMC_MODE_BURST &&
                   REP_INTERVAL_PS_I < `PTMC_BURST_MIN_PS) begin
        err_next = 1'b1;
      end else begin
        mode_next = MODE_I;
      end
    end
    // Edge write: only one polarity at a time
    if (EDGE_WR_I) begin
      if (EDGE_I == `PTMC_EDGE_POS) begin
        neg_next = 1'b0;
      end else if (EDGE_I == `PTMC_EDGE_NEG) begin
        neg_next = 1'b1;
      end else begin
        err_next = 1'b1;
      end
    end
    // Enable write, one flag for both channels
    if (EXT_EN_WR_I) begin
      ext_en_next = EXT_EN_I;
    end
    // Software trigger wins over a same-cycle enable write
    if (SW_SINGLE_TRIGGER_MODE_I) begin
      ext_en_next = 1'b0;
    end
  end

  // Trigger merge: external edge only when enabled
  always @* begin
    ext_single_trigger_mode = ext_edge & ext_en_reg;
    single_trigger_mode = ext_single_trigger_mode | SW_SINGLE_TRIGGER_MODE_I;
  end

  // Accepted trigger: only from idle, so triggers during a pulse are not flagged
  always @* begin
    single_trigger_mode_take = 1'b0;
    if (state_reg == ST_IDLE && single_trigger_mode) begin
      if (mode_reg == `PTMC_MODE_SINGLE_TRIGGER_MODE) begin
        single_trigger_mode_take = 1'b1;
      end else if (mode_reg == `PTMC_MODE_BURST && BURST_COUNT_I != `PTMC_COUNT_ZERO) begin
        single_trigger_mode_take = 1'b1;
      end
    end
  end

  // Pulse sequencer for auto, trigger, gate and burst
  always @* begin
    state_next = state_reg;
    timer_next = timer_reg;
    left_next = left_reg;
    pulse_next = 1'b0;
    case (state_reg)
      // Idle until auto, an open gate or an accepted trigger starts a pulse
      ST_IDLE: begin
        if (mode_reg == `PTMC_MODE_AUTO) begin
          state_next = ST_HIGH;
          timer_next = `PTMC_PULSE_CYC;
        end else if (gate_active(mode_reg, ext_en_reg, ext_level, neg_reg)) begin
          state_next = ST_HIGH;
          timer_next = `PTMC_PULSE_CYC;
        end else if (mode_reg == `PTMC_MODE_SINGLE_TRIGGER_MODE && single_trigger_mode) begin
          state_next = ST_HIGH;
          timer_next = `PTMC_PULSE_CYC;
          left_next = `PTMC_COUNT_ONE;
        end else if (mode_reg == `PTMC_MODE_BURST && single_trigger_mode &&
                     BURST_COUNT_I != `PTMC_COUNT_ZERO) begin
          state_next = ST_HIGH;
          timer_next = `PTMC_PULSE_CYC;
          left_next = BURST_COUNT_I;
        end
      end
      // Pulse high phase, fixed width
      ST_HIGH: begin
        pulse_next = 1'b1;
        if (timer_reg == `PTMC_TIMER_ONE) begin
          state_next = ST_LOW;
          timer_next = `PTMC_GAP_CYC;
        end else begin
          timer_next = tick_down(timer_reg);
        end
      end
      // Gap phase; a mode change other than to external width takes effect only at its end
      ST_LOW: begin
        if (timer_reg != `PTMC_TIMER_ONE) begin
          timer_next = tick_down(timer_reg);
        end else if (mode_reg == `PTMC_MODE_AUTO) begin
          state_next = ST_HIGH;
          timer_next = `PTMC_PULSE_CYC;
        end else if (gate_active(mode_reg, ext_en_reg, ext_level, neg_reg)) begin
          state_next = ST_HIGH;
          timer_next = `PTMC_PULSE_CYC;
        end else if ((mode_reg == `PTMC_MODE_BURST || mode_reg == `PTMC_MODE_SINGLE_TRIGGER_MODE) &&
                     left_reg > `PTMC_COUNT_ONE) begin
          state_next = ST_HIGH;
          timer_next = `PTMC_PULSE_CYC;
          left_next = left_reg - `PTMC_COUNT_ONE;
        end else begin
          state_next = ST_IDLE;
          left_next = `PTMC_COUNT_ZERO;
        end
      end
      // Stray state code, back to idle
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // External width follows the input level directly
    if (mode_reg == `PTMC_MODE_EXTERNAL_WIDTH_MODE) begin
      state_next = ST_IDLE;
      pulse_next = ext_en_reg & ext_prev;
    end
  end

  // State registers
  always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mode_reg <= `PTMC_MODE_AUTO;
      neg_reg <= 1'b0;
      ext_en_reg <= 1'b0;
      err_reg <= 1'b0;
      state_reg <= ST_IDLE;
      timer_reg <= `PTMC_TIMER_ZERO;
      left_reg <= `PTMC_COUNT_ZERO;
    end else begin
      mode_reg <= mode_next;
      neg_reg <= neg_next;
      ext_en_reg <= ext_en_next;
      err_reg <= err_next;
      state_reg <= state_next;
      timer_reg <= timer_next;
      left_reg <= left_next;
    end
  end

  // Output flops, loaded from the same next values so answers track the state
  always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      MODE_O <= `PTMC_MODE_AUTO;
      EDGE_NEG_O <= 1'b0;
      EXT_EN_O <= 1'b0;
      ERR_O <= 1'b0;
      PULSE_O <= 1'b0;
      SINGLE_TRIGGER_MODE_O <= 1'b0;
    end else begin
      MODE_O <= mode_next;
      EDGE_NEG_O <= neg_next;
      EXT_EN_O <= ext_en_next;
      ERR_O <= err_next;
      PULSE_O <= pulse_next;
      SINGLE_TRIGGER_MODE_O <= single_trigger_mode_take;
    end
  end

endmodule
`default_nettype wire

// file: inc/ptmc_defines.vh
// Purpose: Shared constants for the pulse trigger and mode control block
// Assumes: 10 MHz system clock, period 100 ns
// Notes: Mode codes double as the query answer codes
`ifndef PTMC_DEFINES_VH
`define PTMC_DEFINES_VH

// Operating mode codes (3 bits)
`define PTMC_MODE_W 3
`define PTMC_MODE_AUTO 3'h0
`define PTMC_MODE_SINGLE_TRIGGER_MODE 3'h1
`define PTMC_MODE_GATE 3'h2
`define PTMC_MODE_BURST 3'h3
`define PTMC_MODE_EXTERNAL_WIDTH_MODE 3'h4

// Edge select codes for the request port
`define PTMC_EDGE_W 2
`define PTMC_EDGE_POS 2'h0
`define PTMC_EDGE_NEG 2'h1
`define PTMC_EDGE_BOTH 2'h3

// Repetition interval in picoseconds, burst floor 5.00 ns
`define PTMC_PERIOD_W 32
`define PTMC_BURST_MIN_PS 32'h00001388

// Burst count width and reset values
`define PTMC_COUNT_W 16
`define PTMC_COUNT_ONE 16'h0001
`define PTMC_COUNT_ZERO 16'h0000

// Pulse timer: pulse width and gap in system cycles
`define PTMC_TIMER_W 8
`define PTMC_PULSE_CYC 8'h02
`define PTMC_GAP_CYC 8'h02
`define PTMC_TIMER_ONE 8'h01
`define PTMC_TIMER_ZERO 8'h00

`endif

// file: verilog/ptmc_sync.v
// Purpose: Three-flop synchroniser with agreement filter for the trigger pin
// Assumes: Input is asynchronous to the system clock
// Notes: First flop feeds only the second; output moves when stages 2 and 3 agree
`timescale 1ns/10ps
`default_nettype none

module ptmc_sync (
  // Clock and reset
  input wire sys_clk_i,
  input wire arst_n_i,
  // Pin in, clean level out
  input wire pin_i,
  output reg level_o
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // Synchroniser chain and filtered level
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg; // Change counts once both agree
      end
    end
  end

endmodule
`default_nettype wire

// file: verilog/ptmc_edge.v
// Purpose: Edge detector on a synchronised level with polarity select
// Assumes: Input already in the system clock domain
// Notes: One-cycle pulse per qualifying edge
`timescale 1ns/10ps
`default_nettype none

module ptmc_edge (
  // Clock and reset
  input wire sys_clk_i,
  input wire arst_n_i,
  // Level and polarity
  input wire level_i,
  input wire neg_i,
  // Outputs
  output reg edge_o,
  output reg prev_o
);

  // Edge compare against previous level
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_o <= 1'b0;
      edge_o <= 1'b0;
    end else begin
      prev_o <= level_i;
      edge_o <= neg_i ? (prev_o & ~level_i) : (~prev_o & level_i);
    end
  end

endmodule
`default_nettype wire

// file: testbench/ptmc_single_trigger_mode_src.sv
// Purpose: External trigger source model driving the trigger pin
// Assumes: Pin idles low and is not locked to the system clock
// Notes: Edges land 37 ns after a clock edge to look asynchronous
`timescale 1ns/10ps
`default_nettype none

module ptmc_single_trigger_mode_src (
  // Clock used only to pace the pulse
  input wire logic clk_i,
  // Trigger pin
  output var logic pin_o
);
  initial pin_o = 1'b0;

  // One high pulse of n clock periods, also used as a gate
  task automatic pulse(input int n);
    @(posedge clk_i);
    #37 pin_o = 1'b1;
    repeat (n) @(posedge clk_i);
    #37 pin_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: testbench/ptmc_chk.sv
// Purpose: Port level checker for the trigger and mode control
// Assumes: One clock domain, reset asynchronous active low
// Notes: Attached by bind after the module
`timescale 1ns/10ps
`default_nettype none

module ptmc_chk (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  // Requests
  input wire logic MODE_WR_I,
  input wire logic [2:0] MODE_I,
  input wire logic EDGE_WR_I,
  input wire logic [1:0] EDGE_I,
  input wire logic EXT_EN_WR_I,
  input wire logic EXT_EN_I,
  input wire logic SW_SINGLE_TRIGGER_MODE_I,
  input wire logic DUTY_RATIO_MODE_I,
  input wire logic [31:0] REP_INTERVAL_PS_I,
  // Answers
  input wire logic [2:0] MODE_O,
  input wire logic EDGE_NEG_O,
  input wire logic EXT_EN_O,
  input wire logic ERR_O,
  input wire logic PULSE_O,
  input wire logic SINGLE_TRIGGER_MODE_O
);
  logic [3:0] off_cnt_reg;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  // Cycles with the input disabled, long enough to flush the sync pipe
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) off_cnt_reg <= 4'h0;
    else if (EXT_EN_O || SW_SINGLE_TRIGGER_MODE_I) off_cnt_reg <= 4'h0;
    else if (off_cnt_reg != 4'hF) off_cnt_reg <= off_cnt_reg + 4'h1;
  end

  a_mode_bad: assert property (MODE_WR_I && MODE_I > 3'h4 |=> $stable(MODE_O) && ERR_O)
    else $error("illegal mode altered setting");
  a_single_trigger_mode_duty: assert property (MODE_WR_I && MODE_I == 3'h1 && DUTY_RATIO_MODE_I
    |=> $stable(MODE_O) && ERR_O) else $error("trigger mode taken in duty mode");
  a_burst_floor: assert property (MODE_WR_I && MODE_I == 3'h3
    && REP_INTERVAL_PS_I < 32'h1388 |=> $stable(MODE_O) && ERR_O)
    else $error("burst taken below interval floor");
  a_edge_both: assert property (EDGE_WR_I && EDGE_I[1] |=> $stable(EDGE_NEG_O) && ERR_O)
    else $error("edge code not refused");
  a_edge_set: assert property (EDGE_WR_I && !EDGE_I[1] |=> EDGE_NEG_O == $past(EDGE_I[0]))
    else $error("edge setting not taken");
  a_en_set: assert property (EXT_EN_WR_I && !SW_SINGLE_TRIGGER_MODE_I |=> EXT_EN_O == $past(EXT_EN_I))
    else $error("enable setting not taken");
  a_sw_clear: assert property (SW_SINGLE_TRIGGER_MODE_I |=> !EXT_EN_O)
    else $error("soft trigger left enable on");
  a_mode_code: assert property (MODE_O <= 3'h4)
    else $error("mode answer out of range");
  a_single_trigger_mode_mode: assert property (SINGLE_TRIGGER_MODE_O |-> $past(MODE_O) == 3'h1 || $past(MODE_O) == 3'h3)
    else $error("trigger event outside single_trigger_mode or burst");
  a_one_pulse: assert property (SINGLE_TRIGGER_MODE_O && MODE_O == 3'h1 |=> PULSE_O [*2] ##1 !PULSE_O)
    else $error("trigger pulse shape wrong");
  a_ext_off: assert property (off_cnt_reg == 4'hF |-> !SINGLE_TRIGGER_MODE_O)
    else $error("trigger with input disabled");

  c_sw: cover property (SW_SINGLE_TRIGGER_MODE_I ##1 SINGLE_TRIGGER_MODE_O);
  c_burst: cover property (MODE_O == 3'h3 && PULSE_O);
  c_err: cover property ($rose(ERR_O));
endmodule

bind ptmc_top ptmc_chk u_chk (.SYS_CLK_I, .ARST_N_I, .MODE_WR_I, .MODE_I, .EDGE_WR_I,
  .EDGE_I, .EXT_EN_WR_I, .EXT_EN_I, .SW_SINGLE_TRIGGER_MODE_I, .DUTY_RATIO_MODE_I, .REP_INTERVAL_PS_I,
  .MODE_O, .EDGE_NEG_O, .EXT_EN_O, .ERR_O, .PULSE_O, .SINGLE_TRIGGER_MODE_O);
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: Directed bench for the trigger and mode control
// Assumes: 10 MHz clock, settings as one-cycle strobes
// Notes: Pulse counts allow for the pin synchroniser delay
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic clk, rst_n, pin, mwr, ewr, nwr, nen, sw, eclr, duty, pv;
  logic [2:0] md, mo;
  logic [1:0] ed;
  logic [31:0] rep;
  logic [15:0] bc;
  logic eo, no, er, po, to;
  int rs, nh, cyc, n_errors, tests_run, i;

  ptmc_top dut (.SYS_CLK_I(clk), .ARST_N_I(rst_n), .EXT_SINGLE_TRIGGER_MODE_I(pin), .MODE_WR_I(mwr),
    .MODE_I(md), .EDGE_WR_I(ewr), .EDGE_I(ed), .EXT_EN_WR_I(nwr), .EXT_EN_I(nen),
    .SW_SINGLE_TRIGGER_MODE_I(sw), .DUTY_RATIO_MODE_I(duty), .REP_INTERVAL_PS_I(rep), .BURST_COUNT_I(bc),
    .ERR_CLR_I(eclr), .MODE_O(mo), .EDGE_NEG_O(no), .EXT_EN_O(eo), .ERR_O(er),
    .PULSE_O(po), .SINGLE_TRIGGER_MODE_O(to));
  ptmc_single_trigger_mode_src src (.clk_i(clk), .pin_o(pin));

  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, far above the expected few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      test_done;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Strobed write: 0 mode, 1 edge, 2 enable, 3 soft trigger, else clear
  task automatic wr(input int k, input logic [2:0] v);
    @(posedge clk);
    case (k)
      0: begin mwr <= 1'b1; md <= v; end
      1: begin ewr <= 1'b1; ed <= v[1:0]; end
      2: begin nwr <= 1'b1; nen <= v[0]; end
      3: sw <= 1'b1;
      default: eclr <= 1'b1;
    endcase
    @(posedge clk);
    {mwr, ewr, nwr, sw, eclr} <= 5'h00;
    #1;
  endtask

  // Count pulse rises and high cycles over n cycles
  task automatic cnt(input int n);
    rs = 0;
    nh = 0;
    pv = po;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (po === 1'b1) nh++;
      if (po === 1'b1 && pv !== 1'b1) rs++;
      pv = po;
    end
  endtask

  initial begin
    rst_n = 1'b0;
    {mwr, ewr, nwr, nen, sw, eclr, duty} = 7'h00;
    md = 3'h0;
    ed = 2'h0;
    rep = 32'h00002710;
    bc = 16'h0003;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(mo, 3'h0);
    chk({no, eo, er}, 3'h0);
    cnt(20);
    chk(rs > 0, 1'b1);
    for (i = 0; i < 5; i++) begin
      wr(0, i[2:0]);
      chk(mo, i);
    end
    wr(0, 3'h5);
    chk({mo, er}, 4'h9);
    wr(4, 3'h0);
    @(posedge clk) duty <= 1'b1;
    wr(0, 3'h1);
    chk({mo, er}, 4'h9);
    wr(4, 3'h0);
    @(posedge clk) begin duty <= 1'b0; rep <= 32'h00001387; end
    wr(0, 3'h3);
    chk({mo, er}, 4'h9);
    @(posedge clk) rep <= 32'h00001388;
    wr(0, 3'h3);
    chk(mo, 3'h3);
    wr(4, 3'h0);
    wr(1, 3'h3);
    chk({no, er}, 2'h1);
    wr(1, 3'h1);
    chk(no, 1'b1);
    wr(1, 3'h0);
    wr(2, 3'h1);
    chk(eo, 1'b1);
    fork wr(3, 3'h0); cnt(30); join
    chk(eo, 1'b0);
    chk(rs, 3);
    wr(0, 3'h1);
    fork wr(3, 3'h0); cnt(20); join
    chk(rs, 1);
    chk(nh, 2);
    wr(2, 3'h1);
    fork src.pulse(4); cnt(25); join
    chk(rs, 1);
    wr(2, 3'h0);
    fork src.pulse(4); cnt(25); join
    chk(rs, 0);
    wr(2, 3'h1);
    wr(1, 3'h1);
    fork src.pulse(15); cnt(12); join
    chk(rs, 0);
    cnt(15);
    chk(rs, 1);
    wr(1, 3'h0);
    wr(0, 3'h2);
    fork src.pulse(30); cnt(45); join
    chk(rs >= 6, 1'b1);
    cnt(20);
    chk(rs, 0);
    wr(0, 3'h4);
    fork src.pulse(6); cnt(20); join
    chk(nh, 6);
    test_done;
  end
endmodule
`default_nettype wire
